// *** core/sac_top.sv ***
`timescale 1ns/1ns
// Behaviour
// - Input above high reference yields all ones: upper FFh, lower 03h.
// - Input below low reference yields zero in both result registers.
// - Four-bit channel field selects one of sixteen inputs directly.
// - Setting converter_on starts continuous conversion of the selected channel.
// - Done flag stays set while the next conversion is in progress, until the upper byte is read.
// - Writing the channel during conversion restarts on the new channel.
// - End of conversion sets done flag in bit 7 and loads result.
// - Completed conversion with done_irq_enable set raises an interrupt request.
// - Stored result stays unchanged until the next conversion finishes.
// - Reading the upper result byte clears the done flag and releases the lock.
// - Reading the lower result bits locks both result registers.
// - Lock releases on upper byte read or converter_on cleared.
// - Divider field bits 6:5 picks 4, 2 or 1 MHz converter clock.
// - Clearing converter_on stops conversion and powers the converter down.
// - Upper holds bits 9:2; lower holds bits 1:0, bits 7:2 zero.
// - Wait leaves converter running and wakes; Halt disables, no wake.
module sac_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // AXI4-Lite write address and data
  input wire logic [sac_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read
  input wire logic [sac_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Power modes
  input wire logic i_halt,
  input wire logic i_wait,
  // Analog core
  input wire logic i_comp,
  output logic o_conv_power,
  output logic [sac_pkg::CH_W-1:0] o_channel,
  output logic o_sample,
  output logic [sac_pkg::RES_W-1:0] o_dac_code,
  // Events
  output logic o_irq,
  output logic o_wake
);
  import sac_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wbyte_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rd_hit;
  logic wr_fire;
  logic ar_fire;
  logic csr_wr;
  logic clkctl_wr;
  logic upper_rd;
  logic lower_rd;
  logic [1:0] div_reg;
  logic on_reg;
  logic [CH_W-1:0] chan_reg;
  logic ie_reg;
  logic sts_reg;
  logic eoc_reg;
  logic lock_reg;
  logic [RES_W-1:0] data_reg;
  logic restart;
  logic tick;
  logic busy;
  logic done;
  logic [RES_W-1:0] result;
  sac_cfg_s cfg;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign o_s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign o_s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign csr_wr = wr_fire && wstrb0_reg && sac_addr_hit(awaddr_reg, CSR_IDX);
  assign clkctl_wr = wr_fire && wstrb0_reg && sac_addr_hit(awaddr_reg, CLKCTL_IDX);

  // Address and data holds, taken in either order
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wbyte_reg <= '0;
      wstrb0_reg <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= i_s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wbyte_reg <= i_s_axi_wdata[7:0];
        wstrb0_reg <= i_s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // Write response, unmapped addresses answer SLVERR
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (sac_addr_hit(awaddr_reg, CSR_IDX) || sac_addr_hit(awaddr_reg, UPPER_IDX)
                    || sac_addr_hit(awaddr_reg, LOWER_IDX)
                    || sac_addr_hit(awaddr_reg, CLKCTL_IDX)) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign o_s_axi_arready = !rvalid_reg;
  assign ar_fire = i_s_axi_arvalid && o_s_axi_arready;
  assign upper_rd = ar_fire && sac_addr_hit(i_s_axi_araddr, UPPER_IDX);
  assign lower_rd = ar_fire && sac_addr_hit(i_s_axi_araddr, LOWER_IDX);

  // Read data mux
  always_comb begin
    rdata_next = '0;
    rd_hit = 1'b1;
    if (sac_addr_hit(i_s_axi_araddr, CSR_IDX)) begin
      rdata_next[EOC_BIT] = eoc_reg;
      rdata_next[DIV_LSB +: 2] = div_reg;
      rdata_next[ON_BIT] = on_reg;
      rdata_next[CH_LSB +: CH_W] = chan_reg;
    end else if (sac_addr_hit(i_s_axi_araddr, UPPER_IDX)) begin
      rdata_next[7:0] = data_reg[RES_W-1:UPPER_LSB];
    end else if (sac_addr_hit(i_s_axi_araddr, LOWER_IDX)) begin
      rdata_next[UPPER_LSB-1:0] = data_reg[UPPER_LSB-1:0];
    end else if (sac_addr_hit(i_s_axi_araddr, CLKCTL_IDX)) begin
      rdata_next[IE_BIT] = ie_reg;
      rdata_next[STS_BIT] = sts_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read response register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rdata_next;
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_s_axi_rdata = rdata_reg;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Divider, on bit and channel
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_reg <= CSR_RST[DIV_LSB +: 2];
      on_reg <= CSR_RST[ON_BIT];
      chan_reg <= CSR_RST[CH_LSB +: CH_W];
    end else if (csr_wr) begin
      div_reg <= wbyte_reg[DIV_LSB +: 2];
      on_reg <= wbyte_reg[ON_BIT];
      chan_reg <= wbyte_reg[CH_LSB +: CH_W];
    end
  end

  // Interrupt enable and sample stretch
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ie_reg <= 1'b0;
      sts_reg <= 1'b0;
    end else if (clkctl_wr) begin
      ie_reg <= wbyte_reg[IE_BIT];
      sts_reg <= wbyte_reg[STS_BIT];
    end
  end

  // ****************************************************************
  // Conversion engine
  // ****************************************************************
  // One driver for the whole configuration word
  assign cfg = '{div: div_reg, on: on_reg && !i_halt, chan: chan_reg,
                 stretch: sts_reg};
  assign restart = csr_wr && wbyte_reg[ON_BIT];
  assign o_conv_power = cfg.on;
  assign o_channel = chan_reg;

  sac_clk_div u_clk_div (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_enable(cfg.on),
    .i_div_sel(div_reg),
    .o_tick(tick)
  );

  sac_sar_seq u_sar_seq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_cfg(cfg),
    .i_restart(restart),
    .i_tick(tick),
    .i_comp(i_comp),
    .o_sample(o_sample),
    .o_dac_code(o_dac_code),
    .o_busy(busy),
    .o_done(done),
    .o_result(result)
  );

  // ****************************************************************
  // Done flag, lock and result
  // ****************************************************************
  // Done flag, a set wins over the clearing read
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      eoc_reg <= CSR_RST[EOC_BIT];
    end else if (done) begin
      eoc_reg <= 1'b1;
    end else if (upper_rd) begin
      eoc_reg <= 1'b0;
    end
  end

  // Consistency lock between the two result reads
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lock_reg <= 1'b0;
    end else if (upper_rd || !on_reg) begin
      lock_reg <= 1'b0;
    end else if (lower_rd) begin
      lock_reg <= 1'b1;
    end
  end

  // Result held until the next unlocked completion
  // A completion under the lower read is dropped, so both halves stay from one sample
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      data_reg <= DATA_RST;
    end else if (done && !lock_reg && !lower_rd) begin
      data_reg <= result;
    end
  end

  // Request and wake from Wait, Halt has the converter stopped
  assign o_irq = eoc_reg && ie_reg;
  assign o_wake = o_irq && i_wait && !i_halt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  eoc_only_done_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(eoc_reg) && eoc_reg |-> $past(done))
    else $error("done flag rose without completion");
  done_sets_eoc_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    done |=> eoc_reg)
    else $error("completion did not set done flag");
  upper_clears_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    upper_rd && !done |=> !eoc_reg)
    else $error("upper read left done flag set");
  eoc_sticky_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    eoc_reg && !upper_rd |=> eoc_reg)
    else $error("done flag cleared without upper read");
  lower_locks_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    lower_rd && on_reg |=> lock_reg)
    else $error("lower read did not lock");
  lock_holds_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    lock_reg |=> $stable(data_reg))
    else $error("locked result changed");
  unlock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    upper_rd || !on_reg |=> !lock_reg)
    else $error("lock not released");
  result_stable_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !done |=> $stable(data_reg))
    else $error("result changed without completion");
  irq_follows_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    done && ie_reg && !clkctl_wr |=> o_irq)
    else $error("no interrupt after completion");
  lower_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    lower_rd |=> o_s_axi_rdata[7:UPPER_LSB] == '0)
    else $error("lower register high bits not zero");
  halt_stops_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_halt |=> !busy && !o_wake)
    else $error("converter runs in halt");
  channel_out_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    csr_wr |=> o_channel == $past(wbyte_reg[CH_LSB +: CH_W]))
    else $error("channel output not updated");

  done_seen_c: cover property (@(posedge i_core_clk) disable iff (i_rst) done);
  locked_drop_c: cover property (@(posedge i_core_clk) disable iff (i_rst) done && lock_reg);
  restart_busy_c: cover property (@(posedge i_core_clk) disable iff (i_rst) restart && busy);
  wake_c: cover property (@(posedge i_core_clk) disable iff (i_rst) o_wake);

endmodule // sac_top

// *** core/sac_pkg.sv ***
package sac_pkg;

  // ****************************************************************
  // Clock rates and converter clock dividers
  // ****************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int F_4M_HZ = 4_000_000;
  localparam int F_2M_HZ = 2_000_000;
  localparam int F_1M_HZ = 1_000_000;
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_4M = DIV_W'(CLK_HZ / F_4M_HZ);
  localparam logic [DIV_W-1:0] DIV_2M = DIV_W'(CLK_HZ / F_2M_HZ);
  localparam logic [DIV_W-1:0] DIV_1M = DIV_W'(CLK_HZ / F_1M_HZ);
  localparam logic [1:0] RATE_4M = 2'h0;
  localparam logic [1:0] RATE_2M = 2'h1;
  localparam logic [1:0] RATE_1M = 2'h2;

  // ****************************************************************
  // Conversion geometry
  // ****************************************************************
  localparam int RES_W = 10;
  localparam int CH_W = 4;
  localparam int BIT_W = 4;
  localparam logic [BIT_W-1:0] MSB_IDX_BIT = 4'h9;
  localparam logic [3:0] SAMPLE_TICKS = 4'h2;
  localparam logic [3:0] STRETCH_TICKS = 4'h8;

  // ****************************************************************
  // Register map (printed index, byte address is four times it)
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam logic [7:0] CSR_IDX = 8'h2E;
  localparam logic [7:0] UPPER_IDX = 8'h2F;
  localparam logic [7:0] LOWER_IDX = 8'h30;
  localparam logic [7:0] CLKCTL_IDX = 8'h31;
  localparam int EOC_BIT = 7;
  localparam int DIV_LSB = 5;
  localparam int ON_BIT = 4;
  localparam int CH_LSB = 0;
  localparam int IE_BIT = 0;
  localparam int STS_BIT = 1;
  localparam int UPPER_LSB = 2;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [RES_W-1:0] DATA_RST = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] div;
    logic on;
    logic [CH_W-1:0] chan;
    logic stretch;
  } sac_cfg_s;

  typedef enum {SAC_IDLE, SAC_SAMPLE, SAC_CONVERT} sac_seq_e;

  // Converter clock divider from the rate code, reserved code runs slowest
  function automatic logic [DIV_W-1:0] sac_div_cycles(input logic [1:0] sel);
    case (sel)
      RATE_4M: sac_div_cycles = DIV_4M;
      RATE_2M: sac_div_cycles = DIV_2M;
      RATE_1M: sac_div_cycles = DIV_1M;
      default: sac_div_cycles = DIV_1M;
    endcase
  endfunction

  // Aligned word hit on a register index
  function automatic logic sac_addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    sac_addr_hit = (addr == {idx, 2'h0});
  endfunction

endpackage

// *** core/sac_clk_div.sv ***
`timescale 1ns/1ns
module sac_clk_div (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_enable,
  input wire logic [1:0] i_div_sel,
  // Converter clock enable
  output logic o_tick
);
  import sac_pkg::*;

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] limit;

  // Terminal count from the rate code
  assign limit = sac_div_cycles(i_div_sel);
  assign o_tick = i_enable && (cnt_reg >= limit - 7'h01);

  // Free counter while the converter is on
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_enable || o_tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  tick_spacing_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_tick |-> cnt_reg == limit - 7'h01)
    else $error("converter tick at wrong count");
  reserved_slow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_div_sel == 2'h3) |-> cnt_reg < DIV_1M)
    else $error("reserved rate not slowest");

endmodule // sac_clk_div

// *** core/sac_sar_seq.sv ***
`timescale 1ns/1ns
module sac_sar_seq (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire sac_pkg::sac_cfg_s i_cfg,
  input wire logic i_restart,
  input wire logic i_tick,
  // Analog core
  input wire logic i_comp,
  output logic o_sample,
  output logic [sac_pkg::RES_W-1:0] o_dac_code,
  // Result
  output logic o_busy,
  output logic o_done,
  output logic [sac_pkg::RES_W-1:0] o_result
);
  import sac_pkg::*;

  sac_seq_e state_reg;
  logic comp_meta_reg;
  logic comp_sync_reg;
  logic [3:0] cnt_reg;
  logic [BIT_W-1:0] idx_reg;
  logic [RES_W-1:0] code_reg;
  logic [RES_W-1:0] code_eval;
  logic [3:0] sample_len;

  // Comparator synchroniser
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= i_comp;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // Trial bit kept when the input is at or above the trial level
  always_comb begin
    code_eval = code_reg;
    code_eval[idx_reg] = comp_sync_reg;
  end
  assign sample_len = i_cfg.stretch ? STRETCH_TICKS : SAMPLE_TICKS;

  // Sample, then ten trials, then sample again
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_cfg.on) begin
      state_reg <= SAC_IDLE;
      cnt_reg <= '0;
      idx_reg <= MSB_IDX_BIT;
      code_reg <= '0;
    end else if (i_restart) begin
      state_reg <= SAC_SAMPLE;
      cnt_reg <= '0;
      idx_reg <= MSB_IDX_BIT;
      code_reg <= '0;
    end else if (i_tick) begin
      case (state_reg)
        SAC_IDLE: begin
          state_reg <= SAC_SAMPLE;
          cnt_reg <= '0;
        end
        SAC_SAMPLE: begin
          if (cnt_reg >= sample_len - 4'h1) begin
            state_reg <= SAC_CONVERT;
            idx_reg <= MSB_IDX_BIT;
            code_reg <= {1'b1, {(RES_W-1){1'b0}}};
          end else begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        SAC_CONVERT: begin
          if (idx_reg == '0) begin
            state_reg <= SAC_SAMPLE;
            cnt_reg <= '0;
            code_reg <= '0;
          end else begin
            code_reg <= code_eval | (RES_W'(1) << (idx_reg - 4'h1));
            idx_reg <= idx_reg - 4'h1;
          end
        end
        default: state_reg <= SAC_IDLE;
      endcase
    end
  end

  // Result and one-cycle done
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_result <= DATA_RST;
    end else begin
      o_done <= 1'b0;
      if (i_cfg.on && !i_restart && i_tick && state_reg == SAC_CONVERT && idx_reg == '0) begin
        o_done <= 1'b1;
        o_result <= code_eval;
      end
    end
  end

  assign o_sample = (state_reg == SAC_SAMPLE);
  assign o_busy = (state_reg != SAC_IDLE);
  assign o_dac_code = code_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  off_stops_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_cfg.on |=> !o_busy && !o_done)
    else $error("conversion runs while off");
  restart_sample_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_restart && i_cfg.on |=> o_sample && !o_done)
    else $error("restart did not begin sampling");

endmodule // sac_sar_seq

// *** tb/sac_tb_analog.sv ***
`timescale 1ns/1ns
// Analog mux and converter core seen from the control logic
module sac_tb_analog (
  // Clock
  input wire logic i_core_clk,
  // Converter side
  input wire logic i_power,
  input wire logic [3:0] i_channel,
  input wire logic [9:0] i_dac_code,
  input wire logic [10:0] i_level [16],
  output logic o_comp
);
  logic flip = 1'b0;
  // Unpowered core gives a changing level, never a held one
  always @(posedge i_core_clk) begin
    flip <= ~flip;
  end
  // Comparator high while the selected level reaches the trial code
  assign o_comp = i_power ? (i_level[i_channel] >= {1'b0, i_dac_code}) : flip;
endmodule // sac_tb_analog

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import sac_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, halt = 0, wt = 0;
  logic awready, wready, bvalid, arready, rvalid, comp, power, smp, irq, wake;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0] r, br;
  logic [3:0] chan;
  logic [9:0] dac;
  logic [10:0] level [16] = '{default: 11'h000};
  int err_count = 0;
  int compares = 0;

  // Clock
  always #5 i_core_clk = ~i_core_clk;

  sac_top i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_halt(halt), .i_wait(wt), .i_comp(comp),
    .o_conv_power(power), .o_channel(chan), .o_sample(smp), .o_dac_code(dac),
    .o_irq(irq), .o_wake(wake));

  sac_tb_analog i_core (.i_core_clk(i_core_clk), .i_power(power), .i_channel(chan),
    .i_dac_code(dac), .i_level(level), .o_comp(comp));

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are judged on settled values before the edge that takes them
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic aw_t, w_t, b_t;
    @(posedge i_core_clk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, val};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge i_core_clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      br = bresp;
      @(posedge i_core_clk);
      if (aw_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
    end while (b_t !== 1'b1);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] idx);
    logic ar_t, r_t;
    @(posedge i_core_clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge i_core_clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge i_core_clk);
      if (ar_t) arvalid <= 0;
    end while (r_t !== 1'b1);
    rready <= 0;
  endtask

  task automatic rck(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(d, exp);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  // Polls the control register until the done flag shows
  task automatic wait_done;
    for (int i = 0; i < 600; i++) begin
      rd(CSR_IDX);
      if (d[7] === 1'b1) return;
    end
    chk(32'h0, 32'h1);
  endtask

  task automatic wait_irq(output int n);
    for (n = 0; n < 2500 && irq !== 1'b1; n++) @(negedge i_core_clk);
    if (irq !== 1'b1) chk(32'h0, 32'h1);
    @(posedge i_core_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rck(CSR_IDX, 32'h0);
    rck(UPPER_IDX, 32'h0);
    rck(LOWER_IDX, 32'h0);
    rd(8'h10);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h10, 8'hFF);
    chk(32'(br), 32'(RESP_SLVERR));
  endtask

  task automatic t_full;
    level[3] = 11'h7FF;
    wr(CSR_IDX, 8'h13);
    chk(32'(br), 32'(RESP_OKAY));
    chk(32'(chan), 32'h3);
    wait_done;
    rck(LOWER_IDX, 32'h03);
    rck(UPPER_IDX, 32'hFF);
    rck(CSR_IDX, 32'h13);
  endtask

  task automatic t_zero;
    wr(CSR_IDX, 8'h1F);
    chk(32'(chan), 32'hF);
    chk(32'(smp), 32'h1);
    wait_done;
    rck(LOWER_IDX, 32'h0);
    rck(UPPER_IDX, 32'h0);
  endtask

  task automatic t_lock;
    level[5] = 11'h2A5;
    wr(CSR_IDX, 8'h15);
    wait_done;
    rck(LOWER_IDX, 32'h1);
    level[5] = 11'h156;
    repeat (700) @(posedge i_core_clk);
    rck(UPPER_IDX, 32'hA9);
    wait_done;
    rck(LOWER_IDX, 32'h2);
    rck(UPPER_IDX, 32'h55);
  endtask

  task automatic t_irq;
    int n;
    wr(CLKCTL_IDX, 8'h01);
    wait_irq(n);
    chk(32'(irq), 32'h1);
    wt <= 1;
    @(posedge i_core_clk);
    #1 chk(32'(wake), 32'h1);
    @(posedge i_core_clk);
    halt <= 1;
    @(posedge i_core_clk);
    #1 chk(32'({power, wake}), 32'h0);
    @(posedge i_core_clk);
    halt <= 0;
    wt <= 0;
    rd(UPPER_IDX);
    chk(32'(irq), 32'h0);
  endtask

  // Conversion period for every divider code, the last one with stretched sampling
  task automatic t_rate;
    int n, div, len;
    for (int c = 0; c < 4; c++) begin
      div = (c == 0) ? CLK_HZ / F_4M_HZ : (c == 1) ? CLK_HZ / F_2M_HZ : CLK_HZ / F_1M_HZ;
      len = ((c == 3) ? STRETCH_TICKS : SAMPLE_TICKS) + RES_W;
      if (c == 3) wr(CLKCTL_IDX, 8'h03);
      wr(CSR_IDX, {1'b0, 2'(c), 5'h15});
      rd(UPPER_IDX);
      wait_irq(n);
      rd(UPPER_IDX);
      wait_irq(n);
      chk(32'(n >= (len - 1) * div && n <= (len + 1) * div), 32'h1);
    end
    rck(CLKCTL_IDX, 32'h03);
    wr(CSR_IDX, 8'h05);
    chk(32'(power), 32'h0);
    rd(UPPER_IDX);
    repeat (400) @(posedge i_core_clk);
    rck(CSR_IDX, 32'h05);
  endtask

  task automatic conclude;
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst <= 0;
    t_reset;
    t_full;
    t_zero;
    t_lock;
    t_irq;
    t_rate;
    conclude;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge i_core_clk);
    err_count++;
    conclude;
  end
endmodule // testbench
